/* File: hdl/csj_decoder.sv */
// classifies one compact or extended instruction into an operation
// assumes is_ext tells whether instr holds a two-halfword instruction
`timescale 1ns/1ps
`default_nettype none
module csj_decoder
   import csj_pkg::*;
(
   input wire logic [31:0] instr,
   input wire logic is_ext,
   output csj_dec_s dec
);
   logic [15:0] h;
   assign h = instr[15:0];
   // =====================================================================
   // decode
   always_comb begin
      dec = '0;
      dec.op = CSJ_OP_NONE;
      if (is_ext) begin
         if (instr[31:27] == OPC_EXTEND && h[15:11] == OPC_TWO_REG && h[10:8] == 3'h0
               && h[4:0] == FN_SRL_IMM && instr[20:16] == 5'h00) begin
            dec.op = CSJ_OP_SRL_IMM;
            dec.src_a = csj_xlat(h[7:5]);
            dec.dst = csj_xlat(h[7:5]);
            dec.shamt = {instr[21], instr[26:22]};
            dec.is64 = 1'b1;
         end else if (instr[31:27] == OPC_REGION_CALL && !instr[26]) begin
            dec.op = CSJ_OP_REGION_CALL;
            dec.target = {instr[20:16], instr[25:21], instr[15:0]};
            dec.dst = GPR_LINK;
            dec.link = 1'b1;
         end
      end else if (h[15:11] == OPC_TWO_REG && h[4:0] == FN_SRL_VAR) begin
         dec.op = CSJ_OP_SRL_VAR;
         dec.src_a = csj_xlat(h[7:5]);
         dec.src_b = csj_xlat(h[10:8]);
         dec.dst = csj_xlat(h[7:5]);
         dec.is64 = 1'b1;
      end else if (h[15:11] == OPC_THREE_REG && h[1:0] == FN_SUB) begin
         dec.op = CSJ_OP_SUB;
         dec.src_a = csj_xlat(h[10:8]);
         dec.src_b = csj_xlat(h[7:5]);
         dec.dst = csj_xlat(h[4:2]);
         dec.is64 = 1'b1;
      end else if (h[15:11] == OPC_TWO_REG && h[4:0] == FN_REG_JUMP
            && !(h[6] && h[5])) begin
         // no-slot, link and source-select bits pick one of six forms
         dec.op = CSJ_OP_REG_JUMP;
         dec.no_slot = h[7];
         dec.link = h[6];
         dec.src_a = h[5] ? GPR_LINK : csj_xlat(h[10:8]);
         dec.dst = GPR_LINK;
      end
   end
endmodule // csj_decoder
`default_nettype wire

/* File: hdl/csj_pkg.sv */
// constants, codes and carriers shared by the shift/subtract/jump unit
// assumes one core clock; register bus is axi4-lite with 32-bit data
`default_nettype none
package csj_pkg;
   // =====================================================================
   // instruction encodings
   localparam logic [4:0] OPC_EXTEND = 5'h1E;
   localparam logic [4:0] OPC_TWO_REG = 5'h1D;
   localparam logic [4:0] OPC_THREE_REG = 5'h1C;
   localparam logic [4:0] OPC_REGION_CALL = 5'h03;
   localparam logic [4:0] FN_SRL_IMM = 5'h08;
   localparam logic [4:0] FN_SRL_VAR = 5'h16;
   localparam logic [4:0] FN_REG_JUMP = 5'h00;
   localparam logic [1:0] FN_SUB = 2'h2;
   localparam logic [4:0] GPR_LINK = 5'h1F;
   // link and slot offsets from the instruction address
   localparam logic [63:0] LINK_OFS_REGION = 64'h6;
   localparam logic [63:0] LINK_OFS_SLOT = 64'h4;
   localparam logic [63:0] LINK_OFS_NO_SLOT = 64'h2;
   localparam logic [63:0] SLOT_OFS_REGION = 64'h4;
   // =====================================================================
   // register map (byte addresses)
   localparam int AXI_AW = 4;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_MASK = 4'h8;
   localparam logic [3:0] OFS_STATE = 4'hC;
   localparam int CTRL_EN64_BIT = 0;
   localparam int EV_RSVD_BIT = 0;
   localparam int EV_ADDR_BIT = 1;
   localparam int EV_JUMP_BIT = 2;
   localparam int EV_W = 3;
   localparam logic CTRL_EN64_RST = 1'b1;
   localparam logic [2:0] MASK_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // =====================================================================
   // carriers
   typedef enum logic [2:0] {
      CSJ_OP_NONE = 3'b000,
      CSJ_OP_SRL_IMM = 3'b001,
      CSJ_OP_SRL_VAR = 3'b010,
      CSJ_OP_SUB = 3'b011,
      CSJ_OP_REGION_CALL = 3'b100,
      CSJ_OP_REG_JUMP = 3'b101
   } csj_op_e;
   typedef struct packed {
      csj_op_e op;
      logic [4:0] src_a;
      logic [4:0] src_b;
      logic [4:0] dst;
      logic [5:0] shamt;
      logic [25:0] target;
      logic no_slot;
      logic link;
      logic is64;
   } csj_dec_s;
   // three-bit compact register field to architectural register
   function automatic logic [4:0] csj_xlat(input logic [2:0] f);
      csj_xlat = (f[2:1] == 2'b00) ? {4'h8, f[0]} : {2'b00, f};
   endfunction
endpackage
`default_nettype wire

/* File: hdl/csj_shifter.sv */
// doubleword logical right shifter, zero fill
// assumes the caller picks the count source
`timescale 1ns/1ps
`default_nettype none
module csj_shifter
   import csj_pkg::*;
(
   input wire logic [63:0] din,
   input wire logic [5:0] amount,
   output logic [63:0] dout
);
   // =====================================================================
   // shift
   always_comb begin
      dout = din >> amount;
   end
endmodule // csj_shifter
`default_nettype wire

/* File: hdl/csj_unit.sv */
// execute unit for doubleword shift, modulo subtract and call/jump forms
// assumes a register file whose read data follows the address combinationally, in the same cycle
// and a fetch stage that hands over one instruction at a time
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module csj_unit
   import csj_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // instruction in
   input wire logic instr_valid,
   input wire logic [31:0] instr,
   input wire logic instr_is_ext,
   input wire logic [63:0] instr_pc,
   output logic instr_ready,
   // register file
   output logic [4:0] rf_raddr_a,
   output logic [4:0] rf_raddr_b,
   input wire logic [63:0] rf_rdata_a,
   input wire logic [63:0] rf_rdata_b,
   output logic rf_we,
   output logic [4:0] rf_waddr,
   output logic [63:0] rf_wdata,
   // completion, control flow, exceptions
   output logic done,
   output logic redirect_valid,
   output logic [63:0] redirect_pc,
   output logic instr_set_mode_bit,
   output logic exc_reserved,
   output logic exc_addr_error,
   output logic irq,
   // axi4-lite slave
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef enum logic [0:0] {
      CSJ_ST_IDLE = 1'b0,
      CSJ_ST_EXEC = 1'b1
   } csj_st_e;

   typedef struct packed {
      csj_st_e st;
      logic in_ready;
      csj_dec_s dec;
      logic [63:0] pc;
      logic [4:0] rsel_a;
      logic [4:0] rsel_b;
      logic we;
      logic [4:0] waddr;
      logic [63:0] wdata;
      logic done;
      logic mode;
      logic slot_pend;
      logic [63:0] slot_pc;
      logic slot_mode;
      logic fetch_chk;
      logic redir;
      logic [63:0] redir_pc;
      logic ri;
      logic ae;
      logic en64;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] mask;
      logic irq;
      logic aw_got;
      logic [AXI_AW-1:0] aw_addr;
      logic w_got;
      logic [31:0] wdata_bus;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } csj_state_s;

   csj_state_s r;
   csj_state_s next_r;
   csj_dec_s in_dec;
   logic [63:0] shift_out;
   logic [5:0] shift_amt;

   // =====================================================================
   // helpers
   csj_decoder u_dec (
      .instr(instr),
      .is_ext(instr_is_ext),
      .dec(in_dec)
   );

   // immediate count comes from the instruction, variable from the register
   assign shift_amt = (r.dec.op == CSJ_OP_SRL_IMM) ? r.dec.shamt : rf_rdata_b[5:0];

   csj_shifter u_shift (
      .din(rf_rdata_a),
      .amount(shift_amt),
      .dout(shift_out)
   );

   function automatic logic mapped(input logic [AXI_AW-1:0] a);
      mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_STATE);
   endfunction

   // =====================================================================
   // next state
   always_comb begin
      logic [EV_W-1:0] ev;
      logic [63:0] tgt;
      logic do_w;
      logic st_rd;
      ev = '0;
      tgt = '0;
      do_w = 1'b0;
      st_rd = 1'b0;
      next_r = r;
      next_r.we = 1'b0;
      next_r.done = 1'b0;
      next_r.redir = 1'b0;
      next_r.ri = 1'b0;
      next_r.ae = 1'b0;

      case (r.st)
         CSJ_ST_IDLE: begin
            if (instr_valid && r.in_ready) begin
               next_r.pc = instr_pc;
               next_r.in_ready = 1'b0;
               if (r.fetch_chk) begin
                  // the fault belongs to the fetch of the target, not the jump
                  next_r.fetch_chk = 1'b0;
                  next_r.ae = 1'b1;
                  next_r.done = 1'b1;
                  ev[EV_ADDR_BIT] = 1'b1;
               end else begin
                  next_r.dec = in_dec;
                  next_r.rsel_a = in_dec.src_a;
                  next_r.rsel_b = in_dec.src_b;
                  next_r.st = CSJ_ST_EXEC;
               end
            end else begin
               next_r.in_ready = 1'b1;
            end
         end
         CSJ_ST_EXEC: begin
            next_r.st = CSJ_ST_IDLE;
            next_r.done = 1'b1;
            // an older jump waits for this slot instruction to finish
            if (r.slot_pend) begin
               next_r.slot_pend = 1'b0;
               next_r.redir = 1'b1;
               next_r.redir_pc = r.slot_pc;
               next_r.mode = r.slot_mode;
               next_r.fetch_chk = r.slot_pc[1];
               ev[EV_JUMP_BIT] = 1'b1;
            end
            if (r.dec.is64 && !r.en64) begin
               next_r.ri = 1'b1;
               ev[EV_RSVD_BIT] = 1'b1;
            end else begin
               case (r.dec.op)
                  CSJ_OP_SRL_IMM, CSJ_OP_SRL_VAR: begin
                     next_r.we = 1'b1;
                     next_r.waddr = r.dec.dst;
                     next_r.wdata = shift_out;
                  end
                  CSJ_OP_SUB: begin
                     // plain modulo difference: no overflow detection exists
                     next_r.we = 1'b1;
                     next_r.waddr = r.dec.dst;
                     next_r.wdata = rf_rdata_a - rf_rdata_b;
                  end
                  CSJ_OP_REGION_CALL: begin
                     tgt = r.pc + SLOT_OFS_REGION;
                     next_r.we = 1'b1;
                     next_r.waddr = GPR_LINK;
                     next_r.wdata = {tgt[63:1] + 63'(LINK_OFS_REGION[63:1]) - 63'(SLOT_OFS_REGION[63:1]), r.mode};
                     next_r.slot_pend = 1'b1;
                     next_r.slot_pc = {tgt[63:28], r.dec.target, 2'b00};
                     next_r.slot_mode = r.mode;
                  end
                  CSJ_OP_REG_JUMP: begin
                     tgt = {rf_rdata_a[63:1], 1'b0};
                     if (r.dec.link) begin
                        next_r.we = 1'b1;
                        next_r.waddr = GPR_LINK;
                        if (r.dec.no_slot) begin
                           next_r.wdata = {r.pc[63:1] + 63'(LINK_OFS_NO_SLOT[63:1]), r.mode};
                        end else begin
                           next_r.wdata = {r.pc[63:1] + 63'(LINK_OFS_SLOT[63:1]), r.mode};
                        end
                     end
                     if (r.dec.no_slot) begin
                        next_r.redir = 1'b1;
                        next_r.redir_pc = tgt;
                        next_r.mode = rf_rdata_a[0];
                        next_r.fetch_chk = tgt[1];
                        ev[EV_JUMP_BIT] = 1'b1;
                     end else begin
                        next_r.slot_pend = 1'b1;
                        next_r.slot_pc = tgt;
                        next_r.slot_mode = rf_rdata_a[0];
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         default: begin
            next_r.st = CSJ_ST_IDLE;
         end
      endcase

      // =================================================================
      // write channel: address and data taken in either order
      if (s_axi_awvalid && r.awready) begin
         next_r.aw_got = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         next_r.w_got = 1'b1;
         next_r.wdata_bus = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.aw_got && r.w_got && !r.bvalid) begin
         do_w = 1'b1;
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = mapped(r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end
      if (do_w && r.wstrb[0]) begin
         if (r.aw_addr == OFS_CTRL) begin
            next_r.en64 = r.wdata_bus[CTRL_EN64_BIT];
         end
         if (r.aw_addr == OFS_MASK) begin
            next_r.mask = r.wdata_bus[EV_W-1:0];
         end
      end
      next_r.awready = !next_r.aw_got && !next_r.bvalid;
      next_r.wready = !next_r.w_got && !next_r.bvalid;

      // =================================================================
      // read channel: one read in flight, answered the cycle after
      if (s_axi_arvalid && r.arready) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_CTRL: next_r.rdata = {31'h0, r.en64};
            OFS_STATUS: begin
               next_r.rdata = {29'h0, r.status};
               st_rd = 1'b1;
            end
            OFS_MASK: next_r.rdata = {29'h0, r.mask};
            OFS_STATE: next_r.rdata = {28'h0, r.fetch_chk, r.slot_pend, r.st, r.mode};
            default: next_r.rdata = 32'h0;
         endcase
      end else if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end
      next_r.arready = !next_r.rvalid;

      // read clears status; an event in the same cycle still lands
      next_r.status = (st_rd ? '0 : r.status) | ev;
      next_r.irq = |(next_r.status & next_r.mask);
   end

   // =====================================================================
   // state register
   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
         r.st <= CSJ_ST_IDLE;
         r.dec.op <= CSJ_OP_NONE;
         r.en64 <= CTRL_EN64_RST;
         r.mask <= MASK_RST;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // =====================================================================
   // outputs, all straight from the state register
   assign instr_ready = r.in_ready;
   assign rf_raddr_a = r.rsel_a;
   assign rf_raddr_b = r.rsel_b;
   assign rf_we = r.we;
   assign rf_waddr = r.waddr;
   assign rf_wdata = r.wdata;
   assign done = r.done;
   assign redirect_valid = r.redir;
   assign redirect_pc = r.redir_pc;
   assign instr_set_mode_bit = r.mode;
   assign exc_reserved = r.ri;
   assign exc_addr_error = r.ae;
   assign irq = r.irq;
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bresp = r.bresp;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_arready = r.arready;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign s_axi_rvalid = r.rvalid;
endmodule // csj_unit
`default_nettype wire

/* File: sim/csj_unit_assertions.sv */
// assertion checker for csj_unit, attached by bind below
// assumes one clock and a synchronous reset; sees only the unit's ports
`timescale 1ns/1ps
`default_nettype none
module csj_unit_assertions
   import csj_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire logic rf_we,
   input wire logic [4:0] rf_waddr,
   input wire logic [63:0] rf_wdata,
   input wire logic done,
   input wire logic redirect_valid,
   input wire logic [63:0] redirect_pc,
   input wire logic instr_set_mode_bit,
   input wire logic exc_reserved,
   input wire logic exc_addr_error,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   // ======================================================================
   // properties
   default clocking cb @(posedge clk);
   endclocking
   // a frozen core stretches every latency, so attempts that see ce low are dropped
   default disable iff (reset || !ce);
   take_done_a: assert property (instr_valid && instr_ready |-> ##[1:2] done)
      else $error("instruction did not complete in time");
   take_busy_a: assert property (instr_valid && instr_ready |=> !instr_ready)
      else $error("ready stayed high after a take");
   done_ready_a: assert property (done |=> instr_ready)
      else $error("ready not back after completion");
   write_clean_a: assert property (rf_we |-> done && !exc_reserved && !exc_addr_error)
      else $error("register write without clean completion");
   link_mode_a: assert property (rf_we && rf_waddr == GPR_LINK |->
      rf_wdata[0] == $past(instr_set_mode_bit))
      else $error("link bit 0 is not the mode bit");
   target_align_a: assert property (redirect_valid |-> !redirect_pc[0])
      else $error("jump target with bit 0 set");
   mode_redirect_a: assert property ($changed(instr_set_mode_bit) |-> redirect_valid)
      else $error("mode changed without a redirect");
   reserved_nowrite_a: assert property (exc_reserved |-> done && !rf_we)
      else $error("reserved exception with a write");
   addr_abort_a: assert property (exc_addr_error |-> done && !rf_we && !exc_reserved)
      else $error("address error did not abort");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before handshake");
   read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer stood past its handshake");
endmodule // csj_unit_assertions
bind csj_unit csj_unit_assertions u_chk (.clk, .reset, .ce, .instr_valid, .instr_ready, .rf_we,
   .rf_waddr, .rf_wdata, .done, .redirect_valid, .redirect_pc, .instr_set_mode_bit,
   .exc_reserved, .exc_addr_error, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

/* File: sim/csj_unit_tb.sv */
// self-checking bench for csj_unit: instructions, register file and axi4-lite
// assumes the unit alone; the register file is a bench array with combinational read
`timescale 1ns/1ps
`default_nettype none
module csj_unit_tb
   import csj_pkg::*;
;
   // ======================================================================
   // signals
   logic clk, instr_ready, rf_we, done, redirect_valid, instr_set_mode_bit, irq;
   logic exc_reserved, exc_addr_error, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic reset = 1'h1, ce = 1'h1, instr_valid = 1'h0, instr_is_ext = 1'h0;
   logic [31:0] instr = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata;
   logic [63:0] instr_pc = 64'h0, rf_rdata_a, rf_rdata_b, rf_wdata, redirect_pc;
   logic [4:0] rf_raddr_a, rf_raddr_b, rf_waddr;
   logic [AXI_AW-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [63:0] rf [32];
   logic o_we, o_rv, o_md, o_rs, o_ae;
   logic [4:0] o_wa;
   logic [63:0] o_wd, o_pc, v, p;
   logic [2:0] a, b, c;
   logic [5:0] s;
   logic [25:0] t;
   int miscompares = 0, check_count = 0, seed = 32'h28A9;

   csj_unit u_dut (.clk, .reset, .ce, .instr_valid, .instr, .instr_is_ext, .instr_pc,
      .instr_ready, .rf_raddr_a, .rf_raddr_b, .rf_rdata_a, .rf_rdata_b, .rf_we, .rf_waddr,
      .rf_wdata, .done, .redirect_valid, .redirect_pc, .instr_set_mode_bit, .exc_reserved,
      .exc_addr_error, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   assign rf_rdata_a = rf[rf_raddr_a];
   assign rf_rdata_b = rf[rf_raddr_b];
   // write on the falling edge so the array is settled when a task returns
   always @(negedge clk) begin
      if (rf_we === 1'h1) rf[rf_waddr] <= rf_wdata;
   end

   // ======================================================================
   // helpers
   function automatic logic [4:0] xl(input logic [2:0] f);
      return (f[2:1] == 2'h0) ? {4'h8, f[0]} : {2'h0, f};
   endfunction
   function automatic logic [63:0] lk(input logic [63:0] q, input logic [63:0] o, input logic m);
      logic [63:0] r;
      r = q + o;
      return {r[63:1], m};
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic late(input int n);
      if (n >= 100) begin
         miscompares++;
         $display("[ERR] %0t no answer", $time);
      end
   endtask
   task automatic exec(input logic [31:0] i, input logic e, input logic [63:0] q);
      int n;
      n = 0;
      instr <= i;
      instr_is_ext <= e;
      instr_pc <= q;
      instr_valid <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (instr_ready !== 1'h1 && n < 100);
      instr_valid <= 1'h0;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'h1 && n < 100);
      late(n);
      {o_we, o_wa, o_wd, o_rv, o_pc, o_md, o_rs, o_ae} = {rf_we, rf_waddr, rf_wdata,
         redirect_valid, redirect_pc, instr_set_mode_bit, exc_reserved, exc_addr_error};
   endtask
   task automatic axw(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] e);
      int n;
      n = 0;
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 100);
      s_axi_bready <= 1'h0;
      late(n);
      chk(64'(s_axi_bresp), 64'(e));
      @(posedge clk);
   endtask
   task automatic axr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] e);
      int n;
      n = 0;
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 100);
      s_axi_rready <= 1'h0;
      late(n);
      chk(64'({s_axi_rresp, s_axi_rdata}), 64'({e, d}));
      @(posedge clk);
   endtask
   task automatic results();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ======================================================================
   // scenarios
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      results();
   end
   initial begin
      for (int k = 0; k < 32; k++) rf[k] = {$random(seed), $random(seed)};
      repeat (20) @(posedge clk);
      reset <= 1'h0;
      axr(OFS_CTRL, 32'h1, RESP_OKAY);
      axr(OFS_MASK, 32'h0, RESP_OKAY);
      axr(4'h2, 32'h0, RESP_SLVERR);
      axw(4'h2, 32'h7, RESP_SLVERR);
      for (int k = 0; k < 24; k++) begin
         a = 3'($random(seed));
         b = 3'($random(seed));
         c = 3'($random(seed));
         s = (k == 0) ? 6'h0 : (k == 1) ? 6'h3F : 6'($random(seed));
         v = rf[xl(a)];
         exec({5'h1E, s[4:0], s[5], 5'h0, 5'h1D, 3'h0, a, 5'h08}, 1'h1, 64'h100);
         chk(64'({o_we, o_wa}), 64'({1'h1, xl(a)}));
         chk(o_wd, v >> s);
         v = rf[xl(a)];
         p = rf[xl(b)];
         exec({16'h0, 5'h1D, a, b, 5'h16}, 1'h0, 64'h104);
         chk(64'({o_we, o_wa}), 64'({1'h1, xl(b)}));
         chk(o_wd, p >> v[5:0]);
         rf[xl(a)] = (k == 0) ? 64'h0 : {$random(seed), $random(seed)};
         rf[xl(b)] = (k == 0) ? 64'h1 : {$random(seed), $random(seed)};
         v = rf[xl(a)] - rf[xl(b)];
         exec({16'h0, 5'h1C, a, b, c, 2'h2}, 1'h0, 64'h106);
         chk(64'({o_we, o_wa, o_rs}), 64'({1'h1, xl(c), 1'h0}));
         chk(o_wd, v);
      end
      axw(OFS_CTRL, 32'h0, RESP_OKAY);
      axw(OFS_MASK, 32'h1, RESP_OKAY);
      // freeze the core for three edges while the instruction is in flight
      fork
         exec({16'h0, 5'h1C, 3'h2, 3'h3, 3'h4, 2'h2}, 1'h0, 64'h200);
         begin
            @(posedge clk);
            ce <= 1'h0;
            repeat (3) @(posedge clk);
            ce <= 1'h1;
         end
      join
      chk(64'({o_rs, o_we}), 64'h2);
      axr(OFS_MASK, 32'h1, RESP_OKAY);
      chk(64'(irq), 64'h1);
      axr(OFS_STATUS, 32'h1, RESP_OKAY);
      axr(OFS_STATUS, 32'h0, RESP_OKAY);
      chk(64'(irq), 64'h0);
      axw(OFS_CTRL, 32'h1, RESP_OKAY);
      // call at the end of a region: the slot lies in the next one
      p = 64'h0FFF_FFFC;
      t = 26'($random(seed));
      exec({5'h03, 1'h0, t[20:16], t[25:21], t[15:0]}, 1'h1, p);
      chk(64'({o_we, o_wa, o_rv}), 64'({1'h1, GPR_LINK, 1'h0}));
      chk(o_wd, lk(p, 64'h6, 1'h0));
      exec({16'h0, 5'h1C, 3'h2, 3'h3, 3'h4, 2'h2}, 1'h0, p + 64'h4);
      chk(64'({o_we, o_rv, o_md}), 64'h6);
      p = p + 64'h4;
      chk(o_pc, {p[63:28], t, 2'h0});
      v = {$random(seed), $random(seed)};
      v[1:0] = 2'h1;
      rf[5] = v;
      exec({16'h0, 5'h1D, 3'h5, 1'h0, 1'h1, 1'h0, 5'h00}, 1'h0, 64'h300);
      chk(64'({o_we, o_wa, o_rv}), 64'({1'h1, GPR_LINK, 1'h0}));
      chk(o_wd, lk(64'h300, 64'h4, 1'h0));
      exec({16'h0, 5'h1C, 3'h2, 3'h3, 3'h4, 2'h2}, 1'h0, 64'h302);
      chk(64'({o_rv, o_md}), 64'h3);
      chk(o_pc, {v[63:1], 1'h0});
      p = {$random(seed), $random(seed)};
      p[1:0] = 2'h2;
      rf[6] = p;
      exec({16'h0, 5'h1D, 3'h6, 1'h1, 1'h1, 1'h0, 5'h00}, 1'h0, 64'h400);
      chk(64'({o_we, o_rv, o_md, o_ae}), 64'hC);
      chk(o_wd, lk(64'h400, 64'h2, 1'h1));
      chk(o_pc, p);
      exec({16'h0, 5'h1C, 3'h2, 3'h3, 3'h4, 2'h2}, 1'h0, p);
      chk(64'({o_ae, o_we}), 64'h2);
      exec({16'h0, 5'h1D, 3'h5, 1'h1, 1'h0, 1'h0, 5'h00}, 1'h0, 64'h500);
      chk(64'({o_we, o_rv, o_md}), 64'h3);
      chk(64'(irq), 64'h0);
      // plain jump through the return register, with its delay slot
      rf[31] = ~v ^ 64'h2;
      exec({16'h0, 5'h1D, 3'h0, 1'h0, 1'h0, 1'h1, 5'h00}, 1'h0, 64'h600);
      chk(64'({o_we, o_rv}), 64'h0);
      exec({16'h0, 5'h1C, 3'h2, 3'h3, 3'h4, 2'h2}, 1'h0, 64'h602);
      chk(64'({o_rv, o_md}), 64'h2);
      chk(o_pc, ~v ^ 64'h2);
      axr(OFS_STATUS, 32'h6, RESP_OKAY);
      results();
   end
endmodule // csj_unit_tb
`default_nettype wire
